// ==== dv/ars_frame_src.sv ====
// Frame source standing in for the analyzer pipeline
`default_nettype none
module ars_frame_src (
   input  wire logic                hclk,
   output var  ars_pkg::ars_frame_s frame
);
   timeunit 1ns;
   timeprecision 1ps;
   import ars_pkg::*;
   initial frame = '0;
   // ***********************************************************
   // One frame per call, then released
   // ***********************************************************
   task automatic send(input ars_frame_s f);
      ars_frame_s g;
      // Released lines show garbage, never the last frame
      g = ~f;
      g.valid = 1'b0;
      @(posedge hclk);
      frame <= f;
      @(posedge hclk);
      frame <= g;
   endtask
endmodule // ars_frame_src
`default_nettype wire

// ==== dv/tb_ars_top.sv ====
// Self-checking bench for the stats, sampler and mirror block
`default_nettype none
module tb_ars_top;
   timeunit 1ns;
   timeprecision 1ps;
   import ars_pkg::*;
   logic        hclk, hresetn, hreadyout, hresp, hwrite;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, q;
   ars_frame_s  frame;
   ars_out_s    result;
   int          mismatches = 0;
   int          num_checks = 0;
   logic [1:0]  acl_pick = 2'h0;
   ars_top ars_top_inst (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans,
      .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout,
      .hrdata, .hresp, .frame, .result);
   ars_frame_src ars_frame_src_inst (.hclk, .frame);
   // ***********************************************************
   // Bus, frame and compare tasks
   // ***********************************************************
   task automatic chk(input string n, input logic [39:0] e, g);
      num_checks++;
      if (g !== e) begin
         $display("MISMATCH %s exp %h got %h", n, e, g);
         mismatches++;
      end
   endtask
   task automatic xfer(input logic w, input logic [31:0] a, d);
      @(posedge hclk);
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, d);
      xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [31:0] a, e, input string n);
      xfer(1'b0, a, 32'h0000_0000);
      chk(n, e, q);
      chk("hresp", 40'h0, hresp);
   endtask
   task automatic snd(input logic [1:0] p, input logic [13:0] ln,
                      input logic [11:0] v);
      ars_frame_s f;
      f = '0;
      f.valid = 1'b1;
      f.rx_port = p;
      f.phys_port = p;
      f.tx_mask = 4'h1;
      f.ing_ev = 7'h01;
      f.len = ln;
      f.vid = v;
      f.acl_probe = acl_pick;
      ars_frame_src_inst.send(f);
      #1;
   endtask
   task automatic wrap_up;
      if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   initial begin
      repeat (5000) @(posedge hclk);
      mismatches++;
      wrap_up();
   end
   // ***********************************************************
   // Main sequence
   // ***********************************************************
   initial begin
      hresetn = 1'b0;
      htrans = 2'h0;
      hwrite = 1'b0;
      haddr = '0;
      hwdata = '0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      rd(32'h0000_0000, 32'h0000_0000, "ctrl");
      wr(32'h0000_0040, 32'h0000_0001);
      wr(32'h0000_0044, 32'h0000_0001);
      wr(32'h0000_0004, 32'h0000_0001);
      snd(2'h0, 14'h0064, 12'h000);
      snd(2'h0, 14'h0064, 12'h000);
      rd(32'h0000_0100, 32'h0000_00C8, "byte_lsb");
      rd(32'h0000_0104, 32'h0000_0000, "byte_msb");
      rd(32'h0000_0108, 32'h0000_0002, "frm_lsb");
      wr(32'h0000_0104, 32'h0000_00FF);
      wr(32'h0000_0100, 32'hFFFF_FFFF);
      snd(2'h0, 14'h0001, 12'h000);
      rd(32'h0000_0100, 32'h0000_0000, "wrap_lsb");
      rd(32'h0000_0104, 32'h0000_0000, "wrap_msb");
      wr(32'h0000_0300, 32'h0000_0002);
      wr(32'h0000_0304, 32'h0000_0001);
      wr(32'h0000_0310, 32'h0000_0001);
      wr(32'h0000_0314, 32'h0000_0001);
      wr(32'h0000_0320, 32'h0000_5002 | (VMODE_VID << PRB_VMD));
      wr(32'h0000_0324, 32'h0000_0001);
      snd(2'h0, 14'h0040, 12'h005);
      chk("mir3", 40'h7, {result.mirror, result.mirror_probe});
      chk("rx_edit", 40'h0, result.mirror_tx_edit);
      snd(2'h0, 14'h0040, 12'h006);
      chk("mir2", 40'h6, {result.mirror, result.mirror_probe});
      chk("tx_edit", 40'h1, result.mirror_tx_edit);
      acl_pick = 2'h3;
      snd(2'h0, 14'h0040, 12'h006);
      chk("acl_mir", 40'h7, {result.mirror, result.mirror_probe});
      acl_pick = 2'h0;
      wr(32'h0000_0000, 32'h0000_0051);
      wr(32'h0000_000C, 32'h0000_0007);
      wr(32'h0000_0200, 32'h0001_7FFF);
      snd(2'h0, 14'h0040, 12'h000);
      chk("rx_smp", 40'h1_5_0, {3'b000, result.sample, 1'b0,
         result.cpu_queue, 1'b0, result.sample_id});
      chk("rx_ev", 40'h3, result.stat_ev);
      rd(32'h0000_0008, 32'h0000_0003, "sticky");
      wr(32'h0000_0200, 32'h0002_7FFF);
      snd(2'h1, 14'h0040, 12'h000);
      chk("tx_smp", 40'h1_4, {3'b000, result.sample, 1'b0,
         result.sample_id});
      chk("tx_ev", 40'h5, result.stat_ev);
      wr(32'h0000_0008, 32'h0000_0007);
      wr(32'h0000_0200, 32'h0001_0000);
      snd(2'h0, 14'h0040, 12'h000);
      chk("no_smp", 40'h0, result.sample);
      chk("cand_ev", 40'h1, result.stat_ev);
      rd(32'h0000_0008, 32'h0000_0001, "sticky_w1c");
      rd(32'h0000_0204, 32'h0002_0003, "counts");
      wrap_up();
   end
endmodule // tb_ars_top
`default_nettype wire

// ==== src/ars_pkg.sv ====
// Shared constants and types for the router-leg stats, sampler and mirror
`default_nettype none
package ars_pkg;
   // ****************************************************************
   // Sizes
   // ****************************************************************
   localparam int NPORT  = 4;
   localparam int NCPU   = 8;
   localparam int NPROBE = 3;
   localparam int NTYPE  = 8;
   localparam int IEV_W  = 7;
   localparam int EEV_W  = 5;
   localparam int CNT_W  = 40;
   localparam int HI_W   = 8;
   localparam int LEN_W  = 14;
   localparam int RATE_W = 15;
   localparam int SCNT_W = 16;
   localparam logic [1:0] VMODE_VID  = 2'h2;
   localparam logic [1:0] VMODE_FLAG = 2'h1;
   localparam logic [RATE_W-1:0] LFSR_SEED = 15'h0001;

   // ****************************************************************
   // Register pages (haddr[11:8]) and offsets (haddr[7:0])
   // ****************************************************************
   localparam logic [3:0] PG_GLB  = 4'h0;
   localparam logic [3:0] PG_CNT  = 4'h1;
   localparam logic [3:0] PG_SMP  = 4'h2;
   localparam logic [3:0] PG_PRB  = 4'h3;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_BYTE = 8'h04;
   localparam logic [7:0] OFS_STKY = 8'h08;
   localparam logic [7:0] OFS_SMSK = 8'h0C;
   localparam logic [2:0] BLK_IMSK = 3'h2;
   localparam logic [2:0] BLK_EMSK = 3'h3;
   localparam int CTRL_QU  = 4;
   localparam int CTRL_FLD = 8;
   localparam int SMP_DIR  = 16;
   localparam int PRB_VMD  = 2;
   localparam int PRB_MMD  = 4;
   localparam int PRB_VID  = 12;
   localparam int PRB_PHY  = 24;

   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed {
      logic              valid;
      logic [1:0]        rx_port;
      logic [1:0]        phys_port;
      logic              src_cpu;
      logic [2:0]        src_cpu_id;
      logic [NPORT-1:0]  tx_mask;
      logic [NCPU-1:0]   dst_cpu;
      logic [LEN_W-1:0]  len;
      logic [11:0]       vid;
      logic              vlan_mirror;
      logic              smac_mirror;
      logic              dmac_mirror;
      logic              flooded;
      logic [1:0]        acl_probe;
      logic [IEV_W-1:0]  ing_ev;
      logic [EEV_W-1:0]  egr_ev;
   } ars_frame_s;

   typedef struct packed {
      logic       sample;
      logic [2:0] cpu_queue;
      logic [2:0] sample_id;
      logic       mirror;
      logic [1:0] mirror_probe;
      logic       mirror_tx_edit;
      logic [2:0] stat_ev;
   } ars_out_s;

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic [HI_W-1:0]  shadow;
   } ars_cnt_st_s;

   typedef struct packed {
      logic [SCNT_W-1:0] taken;
      logic [SCNT_W-1:0] seen;
   } ars_smp_st_s;
endpackage
`default_nettype wire

// ==== src/ars_sampler.sv ====
// One per-port statistical sampler with its running counts
`default_nettype none
module ars_sampler (
   input  wire logic                        hclk,
   input  wire logic                        hresetn,
   input  wire logic                        cand,
   input  wire logic                        grant,
   input  wire logic [ars_pkg::RATE_W-1:0]  rnd,
   input  wire logic [ars_pkg::RATE_W-1:0]  rate,
   output var  logic                        hit,
   output var  logic [ars_pkg::SCNT_W-1:0]  taken,
   output var  logic [ars_pkg::SCNT_W-1:0]  seen
);
   import ars_pkg::*;
   ars_smp_st_s q, d;

   // Random value runs 1..32767, so rate/32767 is the hit chance
   assign hit = cand && (rnd <= rate);

   always_comb begin
      d = q;
      if (cand) d.seen = q.seen + SCNT_W'(1);
      if (grant) d.taken = q.taken + SCNT_W'(1);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) q <= '0;
      else q <= d;
   end

   assign taken = q.taken;
   assign seen  = q.seen;
endmodule // ars_sampler
`default_nettype wire

// ==== src/ars_stat_cnt.sv ====
// One 40-bit statistics counter with upper-word shadow
`default_nettype none
module ars_stat_cnt (
   input  wire logic                       hclk,
   input  wire logic                       hresetn,
   input  wire logic                       inc,
   input  wire logic [ars_pkg::LEN_W-1:0]  inc_val,
   input  wire logic                       wr_lo,
   input  wire logic                       wr_hi,
   input  wire logic                       rd_lo,
   input  wire logic [31:0]                wdata,
   output var  logic [ars_pkg::CNT_W-1:0]  cnt,
   output var  logic [ars_pkg::HI_W-1:0]   shadow
);
   import ars_pkg::*;
   ars_cnt_st_s q, d;

   always_comb begin
      d = q;
      if (inc) d.cnt = q.cnt + CNT_W'(inc_val);
      if (wr_hi) d.cnt[CNT_W-1:32] = wdata[HI_W-1:0];
      if (wr_lo) d.cnt[31:0] = wdata;
      if (rd_lo) d.shadow = q.cnt[CNT_W-1:32];
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) q <= '0;
      else q <= d;
   end

   assign cnt    = q.cnt;
   assign shadow = q.shadow;
endmodule // ars_stat_cnt
`default_nettype wire

// ==== src/ars_top.sv ====
// Router-leg statistics, frame samplers and mirror probes, AHB-Lite slave
//
// Chosen here: the address map and register access over AHB-Lite.
`default_nettype none
module ars_top (
   input  wire logic                hclk,
   input  wire logic                hresetn,
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output var  logic                hreadyout,
   output var  logic [31:0]         hrdata,
   output var  logic                hresp,
   input  wire ars_pkg::ars_frame_s frame,
   output var  ars_pkg::ars_out_s   result
);
   import ars_pkg::*;

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic                          samp_en;
      logic [2:0]                    cpu_queue;
      logic                          flood_en;
      logic [NTYPE-1:0]              ibyte;
      logic [NTYPE-1:0]              ebyte;
      logic [NTYPE-1:0][IEV_W-1:0]   imask;
      logic [NTYPE-1:0][EEV_W-1:0]   emask;
      logic [2:0]                    sticky;
      logic [2:0]                    smask;
      logic [NPORT-1:0][RATE_W-1:0]  srate;
      logic [NPORT-1:0][1:0]         sdir;
      logic [NPROBE-1:0][1:0]        pdir;
      logic [NPROBE-1:0][1:0]        pvmode;
      logic [NPROBE-1:0][1:0]        pmmode;
      logic [NPROBE-1:0][11:0]       pvid;
      logic [NPROBE-1:0]             pphys;
      logic [NPROBE-1:0][NPORT-1:0]  pport;
      logic [NPROBE-1:0][NCPU-1:0]   prxcpu;
      logic [NPROBE-1:0][NCPU-1:0]   pcpuset;
      logic [RATE_W-1:0]             lfsr;
      logic                          pend;
      logic                          wr;
      logic [11:0]                   addr;
      logic [31:0]                   hrdata;
      logic                          hready;
      ars_out_s                      out;
   } ars_st_s;

   ars_st_s st_q, st_d;

   logic [2*NTYPE-1:0]              inc, cwr_lo, cwr_hi, crd_lo;
   logic [2*NTYPE-1:0][CNT_W-1:0]   cnt;
   logic [2*NTYPE-1:0][HI_W-1:0]    shadow;
   logic [NPORT-1:0]                cand_rx, cand_tx, hit, grant;
   logic [NPORT-1:0][SCNT_W-1:0]    taken, seen;
   logic [NPROBE-1:0]               pm;
   logic                            take, gtx, rxh, txh, vok, mok;
   logic [2:0]                      sev, sclr;
   logic [1:0]                      gport, srcp;
   logic [31:0]                     rdata;

   assign take = hsel && htrans[1] && hready;

   // ****************************************************************
   // Router-leg counters: 0..7 ingress types, 8..15 egress types
   // ****************************************************************
   for (genvar k = 0; k < 2*NTYPE; k++) begin : g_cnt
      if (k < NTYPE) begin : g_i
         assign inc[k] = frame.valid && |(frame.ing_ev & st_q.imask[k]);
      end else begin : g_e
         assign inc[k] = frame.valid &&
                         |(frame.egr_ev & st_q.emask[k-NTYPE]);
      end
      ars_stat_cnt u_cnt (
         .hclk    (hclk),
         .hresetn (hresetn),
         .inc     (inc[k]),
         .inc_val (((k < NTYPE) ? st_q.ibyte[k % NTYPE]
                                : st_q.ebyte[k % NTYPE])
                   ? frame.len : LEN_W'(1)),
         .wr_lo   (cwr_lo[k]),
         .wr_hi   (cwr_hi[k]),
         .rd_lo   (crd_lo[k]),
         .wdata   (hwdata),
         .cnt     (cnt[k]),
         .shadow  (shadow[k])
      );
   end

   // ****************************************************************
   // Samplers, one per port
   // ****************************************************************
   for (genvar p = 0; p < NPORT; p++) begin : g_smp
      assign cand_rx[p] = st_q.samp_en && frame.valid && st_q.sdir[p][0]
                          && !frame.src_cpu && frame.rx_port == 2'(p);
      assign cand_tx[p] = st_q.samp_en && frame.valid && st_q.sdir[p][1]
                          && frame.tx_mask[p];
      ars_sampler u_smp (
         .hclk    (hclk),
         .hresetn (hresetn),
         .cand    (cand_rx[p] || cand_tx[p]),
         .grant   (grant[p]),
         .rnd     (st_q.lfsr),
         .rate    (st_q.srate[p]),
         .hit     (hit[p]),
         .taken   (taken[p]),
         .seen    (seen[p])
      );
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      st_d   = st_q;
      rdata  = '0;
      cwr_lo = '0;
      cwr_hi = '0;
      crd_lo = '0;
      sclr   = '0;
      grant  = '0;
      gtx    = 1'b0;
      gport  = '0;
      pm     = '0;
      rxh    = 1'b0;
      txh    = 1'b0;
      vok    = 1'b0;
      mok    = 1'b0;
      srcp   = '0;
      st_d.lfsr = {st_q.lfsr[13:0], st_q.lfsr[14] ^ st_q.lfsr[13]};

      // Bus: one wait state so read data leaves a flop
      if (st_q.pend) begin
         st_d.pend   = 1'b0;
         st_d.hready = 1'b1;
         unique case (st_q.addr[11:8])
            PG_GLB: begin
               if (st_q.addr[7:5] == BLK_IMSK) begin
                  rdata = 32'(st_q.imask[st_q.addr[4:2]]);
                  if (st_q.wr)
                     st_d.imask[st_q.addr[4:2]] = hwdata[IEV_W-1:0];
               end else if (st_q.addr[7:5] == BLK_EMSK) begin
                  rdata = 32'(st_q.emask[st_q.addr[4:2]]);
                  if (st_q.wr)
                     st_d.emask[st_q.addr[4:2]] = hwdata[EEV_W-1:0];
               end else if (st_q.addr[7:0] == OFS_CTRL) begin
                  rdata[0] = st_q.samp_en;
                  rdata[CTRL_QU+:3] = st_q.cpu_queue;
                  rdata[CTRL_FLD] = st_q.flood_en;
                  if (st_q.wr) begin
                     st_d.samp_en   = hwdata[0];
                     st_d.cpu_queue = hwdata[CTRL_QU+:3];
                     st_d.flood_en  = hwdata[CTRL_FLD];
                  end
               end else if (st_q.addr[7:0] == OFS_BYTE) begin
                  rdata = {16'h0000, st_q.ebyte, st_q.ibyte};
                  if (st_q.wr) {st_d.ebyte, st_d.ibyte} = hwdata[15:0];
               end else if (st_q.addr[7:0] == OFS_STKY) begin
                  rdata = 32'(st_q.sticky);
                  if (st_q.wr) sclr = hwdata[2:0];
               end else if (st_q.addr[7:0] == OFS_SMSK) begin
                  rdata = 32'(st_q.smask);
                  if (st_q.wr) st_d.smask = hwdata[2:0];
               end
            end
            PG_CNT: begin
               if (!st_q.addr[7]) begin
                  if (st_q.addr[2])
                     rdata = 32'(shadow[st_q.addr[6:3]]);
                  else
                     rdata = cnt[st_q.addr[6:3]][31:0];
                  cwr_lo[st_q.addr[6:3]] = st_q.wr && !st_q.addr[2];
                  cwr_hi[st_q.addr[6:3]] = st_q.wr && st_q.addr[2];
                  crd_lo[st_q.addr[6:3]] = !st_q.wr && !st_q.addr[2];
               end
            end
            PG_SMP: begin
               if (st_q.addr[7:5] == 3'h0) begin
                  if (st_q.addr[2]) begin
                     rdata = {taken[st_q.addr[4:3]], seen[st_q.addr[4:3]]};
                  end else begin
                     rdata = {14'h0000, st_q.sdir[st_q.addr[4:3]],
                              1'b0, st_q.srate[st_q.addr[4:3]]};
                     if (st_q.wr) begin
                        st_d.srate[st_q.addr[4:3]] = hwdata[RATE_W-1:0];
                        st_d.sdir[st_q.addr[4:3]]  = hwdata[SMP_DIR+:2];
                     end
                  end
               end
            end
            PG_PRB: begin
               if (st_q.addr[7:6] == 2'h0 && st_q.addr[5:4] != 2'h3) begin
                  unique case (st_q.addr[3:2])
                     2'h0: begin
                        rdata[1:0] = st_q.pdir[st_q.addr[5:4]];
                        rdata[PRB_VMD+:2] = st_q.pvmode[st_q.addr[5:4]];
                        rdata[PRB_MMD+:2] = st_q.pmmode[st_q.addr[5:4]];
                        rdata[PRB_VID+:12] = st_q.pvid[st_q.addr[5:4]];
                        rdata[PRB_PHY] = st_q.pphys[st_q.addr[5:4]];
                        if (st_q.wr) begin
                           st_d.pdir[st_q.addr[5:4]]   = hwdata[1:0];
                           st_d.pvmode[st_q.addr[5:4]] = hwdata[PRB_VMD+:2];
                           st_d.pmmode[st_q.addr[5:4]] = hwdata[PRB_MMD+:2];
                           st_d.pvid[st_q.addr[5:4]]   = hwdata[PRB_VID+:12];
                           st_d.pphys[st_q.addr[5:4]]  = hwdata[PRB_PHY];
                        end
                     end
                     2'h1: begin
                        rdata = 32'(st_q.pport[st_q.addr[5:4]]);
                        if (st_q.wr)
                           st_d.pport[st_q.addr[5:4]] = hwdata[NPORT-1:0];
                     end
                     2'h2: begin
                        rdata = {16'h0000, st_q.pcpuset[st_q.addr[5:4]],
                                 st_q.prxcpu[st_q.addr[5:4]]};
                        if (st_q.wr) begin
                           st_d.prxcpu[st_q.addr[5:4]]  = hwdata[7:0];
                           st_d.pcpuset[st_q.addr[5:4]] = hwdata[15:8];
                        end
                     end
                     2'h3: rdata = '0;
                  endcase
               end
            end
            default: rdata = '0;
         endcase
         if (!st_q.wr) st_d.hrdata = rdata;
      end else if (take) begin
         st_d.pend   = 1'b1;
         st_d.wr     = hwrite;
         st_d.addr   = haddr[11:0];
         st_d.hready = 1'b0;
      end

      // Sampling: the rx port's sampler first, then lowest tx port
      if (hit[frame.rx_port] && cand_rx[frame.rx_port]) begin
         grant[frame.rx_port] = 1'b1;
         gport = frame.rx_port;
      end else begin
         for (int p = NPORT - 1; p >= 0; p--) begin
            if (hit[p] && cand_tx[p]) begin
               gport = 2'(p);
               gtx   = 1'b1;
            end
         end
         if (gtx) grant[gport] = 1'b1;
      end
      sev = {|grant && gtx, |grant && !gtx, |(cand_rx | cand_tx)};
      st_d.sticky = (st_q.sticky & ~sclr) | sev;
      st_d.out.stat_ev   = sev & st_q.smask;
      st_d.out.sample    = |grant;
      st_d.out.cpu_queue = st_q.cpu_queue;
      st_d.out.sample_id = {gtx, gport};

      // Mirror probes; later (higher) probes overwrite earlier ones
      st_d.out.mirror         = 1'b0;
      st_d.out.mirror_probe   = '0;
      st_d.out.mirror_tx_edit = 1'b0;
      for (int i = 0; i < NPROBE; i++) begin
         srcp = st_q.pphys[i] ? frame.phys_port : frame.rx_port;
         rxh  = st_q.pdir[i][1] && (frame.src_cpu
                ? st_q.prxcpu[i][frame.src_cpu_id]
                : st_q.pport[i][srcp]);
         txh  = st_q.pdir[i][0] && (|(frame.tx_mask & st_q.pport[i])
                || |(frame.dst_cpu & st_q.pcpuset[i]));
         unique case (st_q.pvmode[i])
            VMODE_VID:  vok = frame.vid == st_q.pvid[i];
            VMODE_FLAG: vok = frame.vlan_mirror;
            default:    vok = 1'b1;
         endcase
         mok = (!st_q.pmmode[i][1] || frame.smac_mirror) &&
               (!st_q.pmmode[i][0] || frame.dmac_mirror ||
                (st_q.flood_en && frame.flooded));
         if (frame.acl_probe == 2'(i + 1)) begin
            rxh = st_q.pdir[i][1];
            txh = st_q.pdir[i][0] && (|frame.tx_mask || |frame.dst_cpu);
            vok = 1'b1;
            mok = 1'b1;
         end
         pm[i] = frame.valid && (rxh || txh) && vok && mok;
         if (pm[i]) begin
            st_d.out.mirror         = 1'b1;
            st_d.out.mirror_probe   = 2'(i + 1);
            st_d.out.mirror_tx_edit = !rxh;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q        <= '0;
         st_q.lfsr   <= LFSR_SEED;
         st_q.hready <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   assign hreadyout = st_q.hready;
   assign hrdata    = st_q.hrdata;
   assign hresp     = 1'b0;
   assign result    = st_q.out;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_wait_done;
      !hreadyout ##1 hreadyout;
   endsequence

   a_bus_wait: assert property (take |=> s_wait_done)
      else $error("bus answer not after one wait");
   a_grant_single: assert property ($onehot0(grant))
      else $error("frame granted to several samplers");
   a_sample_queue: assert property (|grant |=> result.sample &&
      result.cpu_queue == $past(st_q.cpu_queue))
      else $error("sample lost or wrong queue");
   a_sample_ident: assert property ((|grant && !gtx) |=>
      !result.sample_id[2] && result.sample_id[1:0] == $past(frame.rx_port))
      else $error("rx sample identifier wrong");
   a_rx_cand_off: assert property (!st_q.sdir[0][0] |-> !cand_rx[0])
      else $error("rx candidate with direction off");
   a_sticky_set: assert property (|(cand_rx | cand_tx) |=>
      st_q.sticky[0])
      else $error("candidate sticky not set");
   a_stat_event: assert property ((|(cand_rx | cand_tx) &&
      st_q.smask[0]) |=> result.stat_ev[0])
      else $error("masked event not reported");
   a_probe_high: assert property (pm[2] |=> result.mirror &&
      result.mirror_probe == 2'h3)
      else $error("highest probe not chosen");
   a_no_frame: assert property (!frame.valid |=> !result.mirror &&
      !result.sample)
      else $error("copy without frame");
   a_acl_dir: assert property ((frame.acl_probe == 2'h1 &&
      st_q.pdir[0] == 2'h0 && !pm[1] && !pm[2]) |=> !result.mirror)
      else $error("classifier probe ignored direction");
   a_cnt_frame: assert property ((inc[1] && !st_q.ibyte[1] &&
      !cwr_lo[1] && !cwr_hi[1]) |=> cnt[1] == $past(cnt[1]) + 40'd1)
      else $error("frame count step wrong");
   a_shadow_latch: assert property (crd_lo[0] |=>
      shadow[0] == $past(cnt[0][39:32]))
      else $error("upper word not latched");
endmodule // ars_top
`default_nettype wire
